// >>> rtl/cprc_mem.sv
`timescale 1ns/1ps
module cprc_mem
    import cprc_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int WIDTH = 8
) (
    // Clock
    input wire logic clk,
    // Write port, used when the array is programmed
    input wire logic we,
    input wire logic [ADDR_W-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read port, data one cycle after the address
    input wire logic [ADDR_W-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem_reg [0:(2**ADDR_W)-1];
    logic [WIDTH-1:0] rdata_reg;

    // Array write and registered read
    always_ff @(posedge clk) begin
        if (we) begin
            mem_reg[waddr] <= wdata;
        end
        rdata_reg <= mem_reg[raddr];
    end

    assign rdata = rdata_reg;

endmodule : cprc_mem

// >>> rtl/cprc_pkg.sv
package cprc_pkg;

    // Clock rate of ref_clk
    localparam int CLK_MHZ = 50;

    // Power-on hold of the output-enable/reset pin, least time
    localparam int POR_TIME_NS = 2000;
    localparam int POR_CYCLES = (POR_TIME_NS * CLK_MHZ + 999) / 1000;

    // Low time of the configuration pulse pin, least time
    localparam int CF_PULSE_NS = 1000;
    localparam int CF_CYCLES = (CF_PULSE_NS * CLK_MHZ + 999) / 1000;

    // Sequence timer width, wide enough for both counts
    localparam int TMR_W = 8;

    // Half period of the internal oscillator in ref_clk cycles
    localparam int OSC_HALF_CYCLES = 2;
    localparam int OSC_W = 4;

    // Data and revision widths
    localparam int DATA_W = 8;
    localparam int REV_W = 2;
    localparam int BIT_IDX_W = 3;

    // Reset values and last serial bit index
    localparam logic [REV_W-1:0] REV_RESET = 2'h0;
    localparam logic [BIT_IDX_W-1:0] BIT_IDX_RESET = 3'h0;
    localparam logic [BIT_IDX_W-1:0] BIT_IDX_LAST = 3'h7;

    // Pin-side input vector field positions
    localparam int IN_REV_LSB = 0;
    localparam int IN_CF_POS = 2;
    localparam int IN_BUSY_POS = 3;
    localparam int IN_OE_POS = 4;
    localparam int IN_CE_POS = 5;
    localparam int IN_W = 6;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_POR = 3'h1,
        ST_IDLE = 3'h2,
        ST_PULSE = 3'h4
    } cprc_state_t;

endpackage : cprc_pkg

// >>> rtl/cprc_top.sv
// Function
// - Data pins one to seven float during unclamped programming mode or serial mode.
// - A control bit picks internal oscillator or external clock for read-out.
// - External clock edge advances counter only when all enables and pulse pin allow.
// - Output-enable/reset low holds counter reset and floats data and clock output.
// - Output-enable/reset pin is driven low until power-on sequence ends.
// - Output-enable/reset is always active low, never configurable.
// - Chip select high means standby, counter reset, data and clock output floating.
// - Reconfiguration instruction pulses the open-drain configuration pulse pin low.
// - Pulsing that pin low lets the FPGA restart configuration without power loss.
// - Each rising edge of the pulse pin while the device is active samples the revision selection.
// - That same edge loads the counter with the revision's start address.
// - Serial mode uses data pin zero alone; parallel mode drives a full byte.
// - In parallel mode busy high stops the counter and holds the byte.
`timescale 1ns/1ps
module cprc_top
    import cprc_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // System clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // External configuration clock input
    input wire logic cfg_clk,
    // Plain input pins
    input wire logic ce_n,
    input wire logic busy,
    input wire logic [REV_W-1:0] rev_sel,
    // Open-drain output-enable/reset pin
    input wire logic oe_reset_n_i,
    output logic oe_reset_n_o,
    output logic oe_reset_n_oe,
    // Open-drain configuration pulse pin
    input wire logic config_pulse_n_i,
    output logic config_pulse_n_o,
    output logic config_pulse_n_oe,
    // Data pins
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe,
    output logic [DATA_W-2:0] upper_parallel_data_pins_o,
    output logic [DATA_W-2:0] upper_parallel_data_pins_oe,
    // Clock output pin
    output logic configuration_clock_output,
    output logic configuration_clock_output_oe,
    // Programmed control bits
    input wire logic clk_src_internal,
    input wire logic parallel_mode,
    input wire logic in_system_program_mode,
    input wire logic isp_clamp,
    input wire logic config_instr,
    // Array programming port
    input wire logic prog_we,
    input wire logic [ADDR_W-1:0] prog_addr,
    input wire logic [DATA_W-1:0] prog_wdata,
    // Status
    output logic [ADDR_W-1:0] addr_count,
    output logic standby
);

    // Link domain: reset synchroniser and edge toggle
    logic link_rst_s1_reg;
    logic link_rst_s2_reg;
    logic link_tgl_reg;

    // Level crossing of the reset into the link clock
    always_ff @(posedge cfg_clk) begin
        link_rst_s1_reg <= rst_b;
        link_rst_s2_reg <= link_rst_s1_reg;
    end

    // One toggle per external clock edge, crossed as an event
    always_ff @(posedge cfg_clk) begin
        if (!link_rst_s2_reg) begin
            link_tgl_reg <= 1'b0;
        end else begin
            link_tgl_reg <= ~link_tgl_reg;
        end
    end

    // Ref domain: synchronisers for the toggle and the pins
    logic tgl_s1_reg;
    logic tgl_s2_reg;
    logic tgl_hist_reg;
    logic [IN_W-1:0] in_s1_reg;
    logic [IN_W-1:0] in_s2_reg;
    logic cf_hist_reg;

    // Two flops before any logic, first flop read by the second only
    always_ff @(posedge ref_clk) begin
        tgl_s1_reg <= link_tgl_reg;
        tgl_s2_reg <= tgl_s1_reg;
        in_s1_reg <= {ce_n, oe_reset_n_i, busy, config_pulse_n_i, rev_sel};
        in_s2_reg <= in_s1_reg;
    end

    // Edge history, reset so no false edge after reset
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tgl_hist_reg <= 1'b0;
            cf_hist_reg <= 1'b1;
        end else begin
            tgl_hist_reg <= tgl_s2_reg;
            cf_hist_reg <= in_s2_reg[IN_CF_POS];
        end
    end

    // Decoded pin levels
    wire ce_n_s = in_s2_reg[IN_CE_POS];
    wire oe_reset_n_s = in_s2_reg[IN_OE_POS]; // Low always means reset
    wire busy_s = in_s2_reg[IN_BUSY_POS];
    wire cf_s = in_s2_reg[IN_CF_POS];
    wire [REV_W-1:0] rev_s = in_s2_reg[IN_REV_LSB +: REV_W];
    wire ext_edge = tgl_s2_reg ^ tgl_hist_reg;
    wire cf_rise = cf_s & ~cf_hist_reg;

    // Internal oscillator, derived from ref_clk
    logic [OSC_W-1:0] osc_cnt_reg;
    logic [OSC_W-1:0] osc_cnt_next;
    logic osc_reg;
    wire osc_wrap = (osc_cnt_reg == OSC_W'(OSC_HALF_CYCLES - 1));
    wire osc_tick = osc_wrap & ~osc_reg;
    assign osc_cnt_next = osc_wrap ? '0 : osc_cnt_reg + OSC_W'(1);

    // Oscillator divider
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            osc_cnt_reg <= '0;
            osc_reg <= 1'b0;
        end else begin
            osc_cnt_reg <= osc_cnt_next;
            osc_reg <= osc_wrap ? ~osc_reg : osc_reg;
        end
    end

    // Power-on and configuration pulse sequencer
    cprc_state_t state_reg;
    cprc_state_t state_next;
    logic [TMR_W-1:0] tmr_reg;
    logic [TMR_W-1:0] tmr_next;
    wire por_done = (tmr_reg == TMR_W'(POR_CYCLES - 1));
    wire cf_done = (tmr_reg == TMR_W'(CF_CYCLES - 1));

    // Next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_POR: begin
                if (por_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (config_instr) begin
                    state_next = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (cf_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_POR;
            end
        endcase
    end

    assign tmr_next = (state_next != state_reg) ? '0 : tmr_reg + TMR_W'(1);

    // Sequencer registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_reg <= ST_POR;
            tmr_reg <= '0;
        end else begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
        end
    end

    // Open-drain drives: only ever pull low
    assign oe_reset_n_o = 1'b0;
    assign oe_reset_n_oe = (state_reg == ST_POR);
    assign config_pulse_n_o = 1'b0;
    assign config_pulse_n_oe = (state_reg == ST_PULSE); // FPGA restarts, power kept

    // Read-out enables
    wire active = ~ce_n_s & oe_reset_n_s;
    wire busy_stall = parallel_mode & busy_s;
    wire src_edge = clk_src_internal ? osc_tick : ext_edge;
    wire adv = src_edge & active & ~busy_stall & cf_s;
    wire isp_float = in_system_program_mode & ~isp_clamp;

    // Address counter and revision latch
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic [BIT_IDX_W-1:0] bit_idx_reg;
    logic [BIT_IDX_W-1:0] bit_idx_next;
    logic [REV_W-1:0] rev_reg;
    logic [REV_W-1:0] rev_next;
    wire [ADDR_W-1:0] start_latched = {rev_reg, {(ADDR_W-REV_W){1'b0}}};
    wire [ADDR_W-1:0] start_sampled = {rev_s, {(ADDR_W-REV_W){1'b0}}};
    wire byte_step = parallel_mode | (bit_idx_reg == BIT_IDX_LAST);

    // Counter priority: standby/reset, then reload, then advance
    always_comb begin
        addr_next = addr_reg;
        bit_idx_next = bit_idx_reg;
        rev_next = rev_reg;
        if (!active) begin
            addr_next = start_latched;
            bit_idx_next = BIT_IDX_RESET;
        end else if (cf_rise) begin
            rev_next = rev_s;
            addr_next = start_sampled;
            bit_idx_next = BIT_IDX_RESET;
        end else if (adv) begin
            bit_idx_next = parallel_mode ? BIT_IDX_RESET : bit_idx_reg + BIT_IDX_W'(1);
            addr_next = byte_step ? addr_reg + ADDR_W'(1) : addr_reg;
        end
    end

    // Counter registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            addr_reg <= '0;
            bit_idx_reg <= BIT_IDX_RESET;
            rev_reg <= REV_RESET;
        end else begin
            addr_reg <= addr_next;
            bit_idx_reg <= bit_idx_next;
            rev_reg <= rev_next;
        end
    end

    // Bitstream array
    logic [DATA_W-1:0] mem_rdata;

    cprc_mem #(
        .ADDR_W(ADDR_W),
        .WIDTH(DATA_W)
    ) u_mem (
        .clk(ref_clk),
        .we(prog_we),
        .waddr(prog_addr),
        .wdata(prog_wdata),
        .raddr(addr_reg),
        .rdata(mem_rdata)
    );

    // Output data: whole byte or one bit, MSB first
    logic [DATA_W-1:0] data_reg;
    logic clk_out_reg;
    wire serial_bit = mem_rdata[BIT_IDX_LAST - bit_idx_reg];
    wire [DATA_W-1:0] data_next = parallel_mode ? mem_rdata : {{(DATA_W-1){1'b0}}, serial_bit};

    // Data and clock output flops; data tracks the addressed word
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            data_reg <= '0;
            clk_out_reg <= 1'b0;
        end else begin
            data_reg <= data_next;
            clk_out_reg <= clk_src_internal ? osc_reg : tgl_s2_reg;
        end
    end

    // Pin drive; upper pins only in parallel mode, no data pins during unclamped programming
    assign serial_data_pin_o = data_reg[0];
    assign serial_data_pin_oe = active & ~isp_float;
    assign upper_parallel_data_pins_o = data_reg[DATA_W-1:1];
    assign upper_parallel_data_pins_oe = {(DATA_W-1){active & ~isp_float & parallel_mode}};
    assign configuration_clock_output = clk_out_reg;
    assign configuration_clock_output_oe = active;
    assign addr_count = addr_reg;
    assign standby = ce_n_s;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    chk_isp_tristate: assert property (
        isp_float |-> !serial_data_pin_oe && upper_parallel_data_pins_oe == '0)
        else $error("data pins driven during programming mode");

    chk_serial_upper_off: assert property (
        !parallel_mode |-> upper_parallel_data_pins_oe == '0)
        else $error("upper data pins driven in serial mode");

    chk_ext_adv_cond: assert property (
        (addr_reg != $past(addr_reg)) && $past(active) && !$past(cf_rise) && !$past(clk_src_internal)
        |-> $past(ext_edge) && $past(cf_s) && !$past(busy_stall))
        else $error("counter advanced without a qualified external edge");

    chk_oe_low_reset: assert property (
        !oe_reset_n_s |-> !serial_data_pin_oe && !configuration_clock_output_oe ##1 addr_reg == start_latched)
        else $error("reset pin low did not reset and float");

    chk_por_hold: assert property (
        $rose(rst_b) |-> oe_reset_n_oe [*8])
        else $error("reset pin released too early after power-on");

    chk_standby_float: assert property (
        ce_n_s |-> !serial_data_pin_oe && !configuration_clock_output_oe && standby)
        else $error("outputs driven in standby");

    chk_cf_pulse_len: assert property (
        $rose(config_pulse_n_oe) |-> config_pulse_n_oe [*8])
        else $error("configuration pulse too short");

    chk_cf_reload: assert property (
        active && cf_rise |=> addr_reg == {$past(rev_s), {(ADDR_W-REV_W){1'b0}}} && rev_reg == $past(rev_s))
        else $error("pulse-pin rise did not load revision start");

    chk_busy_hold: assert property (
        active && busy_stall && !cf_rise |=> $stable(addr_reg))
        else $error("counter moved while busy");

    chk_osc_adv_cond: assert property (
        adv && clk_src_internal |-> osc_tick && cf_s)
        else $error("internal advance without oscillator edge");

    chk_data_follow: assert property (
        adv && parallel_mode && !busy_stall ##1 parallel_mode [*2] |-> data_reg == $past(mem_rdata))
        else $error("data pins not following addressed word");

    cov_serial_adv: cover property (adv && !parallel_mode && bit_idx_reg == BIT_IDX_LAST);
    cov_cf_reload: cover property (active && cf_rise);
    cov_busy_stall: cover property (active && busy_stall && src_edge);
    cov_por_done: cover property ($fell(oe_reset_n_oe));

endmodule : cprc_top

// >>> verif/cprc_fpga_model.sv
`timescale 1ns/1ps
module cprc_fpga_model (
    // Bench controls
    input wire logic run,
    input wire logic stall,
    // Pins toward the device
    output logic cfg_clk,
    output logic busy
);
    // Clock stands low between frames, so no stray edge reaches the device
    initial cfg_clk = 1'b0;
    always #16 cfg_clk = run ? ~cfg_clk : 1'b0;

    // Busy only raised when a scenario asks the device to hold its byte
    assign busy = stall;
endmodule : cprc_fpga_model

// >>> verif/cprc_top_test.sv
`timescale 1ns/1ps
module cprc_top_test
    import cprc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce_n = 1'b1;
    logic [1:0] rev_sel = 2'h0;
    logic clk_src_internal = 1'b1;
    logic parallel_mode = 1'b1;
    logic isp = 1'b0;
    logic isp_clamp = 1'b0;
    logic config_instr = 1'b0;
    logic prog_we = 1'b0;
    logic [15:0] prog_addr = 16'h0000;
    logic [7:0] prog_wdata = 8'h00;
    // Link clock runs through reset so the link-side toggle starts from a known level
    logic run = 1'b1;
    logic stall = 1'b0;
    logic hold_oe = 1'b0;
    logic cfg_clk, busy, oe_oe, cf_oe, ser_o, ser_oe, cko, cko_oe, standby;
    logic oe_o, cf_o;
    logic [6:0] up_o, up_oe;
    logic [15:0] addr_count, a;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    // Open-drain wires resolve with their pull-ups
    wire oe_w = (oe_oe ? oe_o : 1'b1) & !hold_oe;
    wire cf_w = cf_oe ? cf_o : 1'b1;

    always #10 ref_clk = ~ref_clk;

    cprc_fpga_model fpga (.run(run), .stall(stall), .cfg_clk(cfg_clk), .busy(busy));

    cprc_top #(.ADDR_W(16)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .cfg_clk(cfg_clk), .ce_n(ce_n), .busy(busy),
        .rev_sel(rev_sel), .oe_reset_n_i(oe_w), .oe_reset_n_o(oe_o), .oe_reset_n_oe(oe_oe),
        .config_pulse_n_i(cf_w), .config_pulse_n_o(cf_o), .config_pulse_n_oe(cf_oe),
        .serial_data_pin_o(ser_o), .serial_data_pin_oe(ser_oe),
        .upper_parallel_data_pins_o(up_o), .upper_parallel_data_pins_oe(up_oe),
        .configuration_clock_output(cko), .configuration_clock_output_oe(cko_oe),
        .clk_src_internal(clk_src_internal), .parallel_mode(parallel_mode),
        .in_system_program_mode(isp), .isp_clamp(isp_clamp), .config_instr(config_instr),
        .prog_we(prog_we), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
        .addr_count(addr_count), .standby(standby)
    );

    // Array contents differ per address and per revision
    function automatic logic [7:0] pat(input logic [15:0] x);
        return (x[7:0] * 8'h1D) ^ x[15:8];
    endfunction : pat

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    task automatic prog(input logic [15:0] x);
        @(negedge ref_clk);
        prog_we = 1'b1;
        prog_addr = x;
        prog_wdata = pat(x);
        @(negedge ref_clk);
        prog_we = 1'b0;
    endtask : prog

    // Bounded wait for the counter to reach a value
    task automatic wait_addr(input logic [15:0] x);
        n = 0;
        while (addr_count !== x && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        check("addr_count", addr_count, x);
    endtask : wait_addr

    // Cuts a hang short
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        repeat (16) @(negedge ref_clk);
        rst_b = 1'b1;
        run = 1'b0;
        @(negedge ref_clk);
        check("oe_hold", oe_oe, 1);
        repeat (110) @(negedge ref_clk);
        check("oe_hold", oe_oe, 0);
        for (int i = 0; i < 16; i++) begin
            prog(16'(i));
            prog(16'h4000 + 16'(i));
        end
        // Byte mode from the internal oscillator
        ce_n = 1'b0;
        wait_addr(16'h0005);
        // Clock output follows the oscillator, one half period per OSC_HALF_CYCLES
        a[0] = cko;
        repeat (OSC_HALF_CYCLES) @(negedge ref_clk);
        check("clk_out", {15'h0000, cko}, {15'h0000, ~a[0]});
        stall = 1'b1;
        repeat (6) @(negedge ref_clk);
        a = addr_count;
        repeat (40) @(negedge ref_clk);
        check("busy_hold", addr_count, a);
        check("byte", {8'h00, up_o, ser_o}, {8'h00, pat(a)});
        check("upper_oe", {9'h000, up_oe}, 16'h007F);
        stall = 1'b0;
        wait_addr(a + 16'h0002);
        // Chip deselect and external reset
        ce_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        check("standby_addr", addr_count, 0);
        check("standby_oe", {standby, ser_oe, up_oe, cko_oe}, 16'h0200);
        ce_n = 1'b0;
        hold_oe = 1'b1;
        repeat (8) @(negedge ref_clk);
        check("oe_low_addr", addr_count, 0);
        check("oe_low_oe", {ser_oe, up_oe, cko_oe}, 0);
        hold_oe = 1'b0;
        // Serial mode from the external clock
        parallel_mode = 1'b0;
        clk_src_internal = 1'b0;
        run = 1'b1;
        wait_addr(16'h0002);
        check("serial_oe", {up_oe, ser_oe}, 16'h0001);
        run = 1'b0;
        repeat (10) @(negedge ref_clk);
        a = addr_count;
        repeat (60) @(negedge ref_clk);
        check("ext_stopped", addr_count, a);
        // Programming mode floats the data pins unless clamped
        isp = 1'b1;
        repeat (5) @(negedge ref_clk);
        check("isp_float", ser_oe, 0);
        isp_clamp = 1'b1;
        repeat (5) @(negedge ref_clk);
        check("isp_clamp", ser_oe, 1);
        isp = 1'b0;
        isp_clamp = 1'b0;
        // Reconfiguration pulse reloads the second revision
        rev_sel = 2'h1;
        config_instr = 1'b1;
        @(negedge ref_clk);
        config_instr = 1'b0;
        repeat (2) @(negedge ref_clk);
        check("pulse", cf_oe, 1);
        repeat (CF_CYCLES + 10) @(negedge ref_clk);
        check("pulse_end", cf_oe, 0);
        check("reload", addr_count, 16'h4000);
        close_out();
    end
endmodule : cprc_top_test
